// file: verilog/aac_pkg.sv
// package: opcode fields, flag positions and timing for the accumulator ops block
package aac_pkg;
	// ----------------------------------------
	// instruction word layout
	// ----------------------------------------
	localparam int INSN_W = 14; // program word width
	localparam int DATA_W = 8; // datapath width
	localparam int IDX_W = 7; // file register index width
	localparam int TOP_HI = 13; // top two bits of the word
	localparam int TOP_LO = 12;
	localparam int OPF_HI = 11; // next four-bit field
	localparam int OPF_LO = 8;
	localparam int DEST_BIT = 7; // destination select bit
	localparam int HALF_BIT = 4; // carry out of bit 3 lands here in a 5-bit sum
	localparam logic [1:0] TOP_LIT = 2'h3; // literal and control group
	localparam logic [1:0] TOP_BYTE = 2'h0; // byte-oriented group
	localparam logic [3:0] OPF_ADDI = 4'he; // 111x, low bit masked
	localparam logic [3:0] OPF_ADDI_MASK = 4'he;
	localparam logic [3:0] OPF_ANDI = 4'h9;
	localparam logic [3:0] OPF_ADDR = 4'h7;
	localparam logic [3:0] OPF_ANDR = 4'h5;
	localparam logic DEST_ACC = 1'b0; // 0: accumulator, 1: file register
	localparam logic [7:0] ACC_RESET = 8'h00;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int OSC_PER_CYCLE = 4; // oscillator periods per instruction cycle
	localparam logic [1:0] PHASE_LAST = 2'(OSC_PER_CYCLE - 1);
	// operation classes
	typedef enum logic [2:0] {
		AAC_OP_NONE = 3'b000,
		AAC_OP_ADDI = 3'b001,
		AAC_OP_ANDI = 3'b010,
		AAC_OP_ADDR = 3'b011,
		AAC_OP_ANDR = 3'b100
	} aac_op_t;
endpackage

// file: verilog/aac_alu.sv
// combinational add/and unit with carry, half carry and zero outputs
`timescale 1ns/1ps
module aac_alu #(
	parameter int W = 8
) (
	// operands
	input wire logic [W-1:0] opA,
	input wire logic [W-1:0] opB,
	input wire logic doAnd,
	// result and flags
	output logic [W-1:0] result,
	output logic carryOut,
	output logic halfOut,
	output logic zeroOut
);
	import aac_pkg::*;
	// full-width and low-nibble sums
	wire logic [W:0] sumFull;
	wire logic [HALF_BIT:0] sumHalf;
	assign sumFull = {1'b0, opA} + {1'b0, opB};
	assign sumHalf = {1'b0, opA[HALF_BIT-1:0]} + {1'b0, opB[HALF_BIT-1:0]};
	assign result = doAnd ? (opA & opB) : sumFull[W-1:0];
	assign carryOut = sumFull[W]; // carry out of bit 7
	assign halfOut = sumHalf[HALF_BIT]; // carry out of bit 3
	assign zeroOut = (result == '0); // zero exactly when result is zero
endmodule

// file: verilog/aac_core.sv
// accumulator execution datapath for add/and with immediate and file operands
// ----------------------------------------
// Summary of operation
// - add immediate to accumulator, update three flags
// - and immediate into accumulator, only zero flag
// - add accumulator and indexed file register, three flags
// - and with file register, only zero flag
// - destination bit picks accumulator or file register
// - one word, one four-phase instruction cycle
// ----------------------------------------
`timescale 1ns/1ps
module aac_core #(
	parameter int PHASES = aac_pkg::OSC_PER_CYCLE
) (
	// clock and reset
	core_clk,
	resetn,
	// instruction from decoder
	insnWord,
	insnValid,
	// file register read port
	fileIdx,
	fileRdData,
	// file register write port
	fileWrEn,
	fileWrData,
	// state
	accOut,
	carryFlag,
	halfByteOverflowFlag,
	zeroFlag,
	cycleDone,
	opAccepted
);
	import aac_pkg::*;
	input wire logic core_clk;
	input wire logic resetn;
	input wire logic [aac_pkg::INSN_W-1:0] insnWord;
	input wire logic insnValid;
	output logic [aac_pkg::IDX_W-1:0] fileIdx;
	input wire logic [aac_pkg::DATA_W-1:0] fileRdData;
	output logic fileWrEn;
	output logic [aac_pkg::DATA_W-1:0] fileWrData;
	output logic [aac_pkg::DATA_W-1:0] accOut;
	output logic carryFlag;
	output logic halfByteOverflowFlag;
	output logic zeroFlag;
	output logic cycleDone;
	output logic opAccepted;

	// ----------------------------------------
	// phase counter: one instruction cycle is four clock phases
	// ----------------------------------------
	logic [1:0] phase_q; // current phase
	logic [1:0] phase_d;
	logic busy_q; // an instruction is in flight
	logic busy_d;
	logic [INSN_W-1:0] insn_q; // latched program word
	logic [INSN_W-1:0] insn_d;
	wire logic lastPhase;
	wire logic startOp;
	assign lastPhase = busy_q && (phase_q == 2'(PHASES - 1));
	// a word is only taken while idle or in the last phase, so words never overlap
	assign startOp = insnValid && (!busy_q || lastPhase);
	assign opAccepted = startOp;
	assign phase_d = startOp ? 2'h0 : (busy_q ? phase_q + 2'h1 : 2'h0);
	assign busy_d = startOp || (busy_q && !lastPhase);
	assign insn_d = startOp ? insnWord : insn_q;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	wire logic [1:0] topBits;
	wire logic [3:0] opField;
	aac_op_t opKind;
	assign topBits = insn_q[TOP_HI:TOP_LO];
	assign opField = insn_q[OPF_HI:OPF_LO];
	// the add-immediate field ignores its low bit, so two field codes map to one op
	assign opKind =
		(topBits == TOP_LIT && (opField & OPF_ADDI_MASK) == OPF_ADDI) ? AAC_OP_ADDI :
		(topBits == TOP_LIT && opField == OPF_ANDI) ? AAC_OP_ANDI :
		(topBits == TOP_BYTE && opField == OPF_ADDR) ? AAC_OP_ADDR :
		(topBits == TOP_BYTE && opField == OPF_ANDR) ? AAC_OP_ANDR :
		AAC_OP_NONE;
	wire logic isImm;
	wire logic isAnd;
	wire logic toFile;
	assign isImm = (opKind == AAC_OP_ADDI) || (opKind == AAC_OP_ANDI);
	assign isAnd = (opKind == AAC_OP_ANDI) || (opKind == AAC_OP_ANDR);
	// other opcodes belong to other units and leave this state alone
	assign toFile = !isImm && (opKind != AAC_OP_NONE) && (insn_q[DEST_BIT] != DEST_ACC);
	assign fileIdx = insn_q[IDX_W-1:0];

	// ----------------------------------------
	// alu
	// ----------------------------------------
	wire logic [DATA_W-1:0] operandB;
	wire logic [DATA_W-1:0] aluRes;
	wire logic aluC;
	wire logic aluH;
	wire logic aluZ;
	assign operandB = isImm ? insn_q[DATA_W-1:0] : fileRdData;
	aac_alu #(.W(DATA_W)) uAlu (
		.opA(accOut),
		.opB(operandB),
		.doAnd(isAnd),
		.result(aluRes),
		.carryOut(aluC),
		.halfOut(aluH),
		.zeroOut(aluZ)
	);

	// ----------------------------------------
	// commit at the end of the instruction cycle
	// ----------------------------------------
	wire logic commit;
	wire logic setArith;
	assign commit = lastPhase && (opKind != AAC_OP_NONE);
	assign setArith = commit && !isAnd; // and ops keep carry flags
	logic [DATA_W-1:0] acc_d;
	logic c_d;
	logic h_d;
	logic z_d;
	assign acc_d = (commit && !toFile) ? aluRes : accOut;
	assign c_d = setArith ? aluC : carryFlag;
	assign h_d = setArith ? aluH : halfByteOverflowFlag;
	assign z_d = commit ? aluZ : zeroFlag;

	// sequencing state
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			phase_q <= 2'h0;
			busy_q <= 1'b0;
			insn_q <= '0;
		end else begin
			phase_q <= phase_d;
			busy_q <= busy_d;
			insn_q <= insn_d;
		end
	end

	// architectural state and write port
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			accOut <= ACC_RESET;
			carryFlag <= 1'b0;
			halfByteOverflowFlag <= 1'b0;
			zeroFlag <= 1'b0;
			fileWrEn <= 1'b0;
			fileWrData <= '0;
			cycleDone <= 1'b0;
		end else begin
			accOut <= acc_d;
			carryFlag <= c_d;
			halfByteOverflowFlag <= h_d;
			zeroFlag <= z_d;
			fileWrEn <= commit && toFile;
			fileWrData <= (commit && toFile) ? aluRes : fileWrData;
			cycleDone <= lastPhase;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	// reference sums built apart from the alu, so a broken adder cannot agree with itself
	wire logic [DATA_W:0] refSum;
	wire logic [HALF_BIT:0] refLow;
	wire logic refCarry;
	wire logic refHalf;
	wire logic refZero;
	assign refSum = {1'b0, accOut} + {1'b0, operandB};
	assign refLow = {1'b0, accOut[HALF_BIT-1:0]} + {1'b0, operandB[HALF_BIT-1:0]};
	assign refCarry = refSum[DATA_W];
	assign refHalf = refLow[HALF_BIT];
	// and ops compare against a plain mask, add ops against the reference sum
	assign refZero = isAnd ? ((accOut & operandB) == '0) : (refSum[DATA_W-1:0] == '0);
	a_cycle_length: assert property (@(posedge core_clk) disable iff (!resetn)
		startOp |=> !lastPhase [*3] ##1 lastPhase)
		else $error("instruction cycle not four phases");
	a_addi_result: assert property (@(posedge core_clk) disable iff (!resetn)
		(commit && opKind == AAC_OP_ADDI) |=> accOut == 8'($past(accOut) + $past(insn_q[7:0])))
		else $error("add immediate result wrong");
	a_andi_flags: assert property (@(posedge core_clk) disable iff (!resetn)
		(commit && opKind == AAC_OP_ANDI) |=> $stable(carryFlag) && $stable(halfByteOverflowFlag)
			&& accOut == ($past(accOut) & $past(insn_q[7:0])))
		else $error("and immediate touched carry flags or wrong result");
	a_addr_carry: assert property (@(posedge core_clk) disable iff (!resetn)
		(commit && opKind == AAC_OP_ADDR) |=> carryFlag == $past(aluC)
			&& fileWrData == ($past(toFile) ? 8'($past(accOut) + $past(fileRdData)) : fileWrData))
		else $error("add register carry or sum wrong");
	a_andr_keep: assert property (@(posedge core_clk) disable iff (!resetn)
		(commit && opKind == AAC_OP_ANDR) |=> $stable(carryFlag) && $stable(halfByteOverflowFlag))
		else $error("and register changed carry flags");
	a_dest_file: assert property (@(posedge core_clk) disable iff (!resetn)
		(commit && toFile) |=> fileWrEn && $stable(accOut))
		else $error("file destination wrote accumulator");
	a_dest_acc: assert property (@(posedge core_clk) disable iff (!resetn)
		(commit && !toFile) |=> !fileWrEn)
		else $error("accumulator destination wrote file");
	a_zero_exact: assert property (@(posedge core_clk) disable iff (!resetn)
		$past(commit) |-> zeroFlag == ($past(aluRes) == 8'h00))
		else $error("zero flag mismatch");
	a_arith_flags: assert property (@(posedge core_clk) disable iff (!resetn)
		setArith |=> carryFlag == $past(refCarry) && halfByteOverflowFlag == $past(refHalf))
		else $error("carry or half carry differs from reference sum");
	a_zero_ref: assert property (@(posedge core_clk) disable iff (!resetn)
		commit |=> zeroFlag == $past(refZero))
		else $error("zero flag differs from reference result");
	a_addr_acc: assert property (@(posedge core_clk) disable iff (!resetn)
		(commit && opKind == AAC_OP_ADDR && !toFile) |=> accOut == 8'($past(accOut) + $past(fileRdData)))
		else $error("add register accumulator sum wrong");
	a_andr_file: assert property (@(posedge core_clk) disable iff (!resetn)
		(commit && opKind == AAC_OP_ANDR && toFile) |=> fileWrData == ($past(accOut) & $past(fileRdData)))
		else $error("and register file result wrong");
	a_done_after: assert property (@(posedge core_clk) disable iff (!resetn)
		startOp |-> ##5 cycleDone)
		else $error("done pulse not one instruction cycle after acceptance");
	// words for other units must leave the accumulator, zero flag and file untouched
	a_other_quiet: assert property (@(posedge core_clk) disable iff (!resetn)
		(lastPhase && opKind == AAC_OP_NONE) |=> $stable(accOut) && $stable(zeroFlag) && !fileWrEn)
		else $error("foreign word changed block state");
	c_addi: cover property (@(posedge core_clk) disable iff (!resetn) commit && opKind == AAC_OP_ADDI);
	c_andr_file: cover property (@(posedge core_clk) disable iff (!resetn)
		commit && opKind == AAC_OP_ANDR && toFile);
	c_carry_set: cover property (@(posedge core_clk) disable iff (!resetn) setArith && aluC && aluH);
	c_back_to_back: cover property (@(posedge core_clk) disable iff (!resetn) lastPhase && startOp);
	c_zero_add: cover property (@(posedge core_clk) disable iff (!resetn) setArith && aluZ && aluC);
endmodule

// file: testbench/aac_file_model.sv
// file register memory model facing the accumulator ops block
`timescale 1ns/1ps
module aac_file_model import aac_pkg::*; (
	// clock
	input wire logic core_clk,
	// read and write port
	input wire logic [IDX_W-1:0] fileIdx,
	input wire logic fileWrEn,
	input wire logic [DATA_W-1:0] fileWrData,
	output logic [DATA_W-1:0] fileRdData
);
	// ----------------------------------------
	// storage
	// ----------------------------------------
	logic [DATA_W-1:0] mem [0:127]; // preset to index xor 8'ha5 so every cell differs
	initial begin
		for (int i = 0; i < 128; i++) begin
			mem[i] = 8'(i) ^ 8'ha5;
		end
	end
	// write lands one edge after the commit edge, from the registered write enable; read is combinational
	always @(posedge core_clk) begin
		if (fileWrEn) begin
			mem[fileIdx] <= fileWrData;
		end
	end
	assign fileRdData = mem[fileIdx];
endmodule

// file: testbench/aac_core_bench.sv
// bench: add and and operations with immediate and file register operands
`timescale 1ns/1ps
module aac_core_bench;
	import aac_pkg::*;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic core_clk = 0;
	logic resetn = 0;
	logic [INSN_W-1:0] insnWord = '0;
	logic insnValid = 0;
	logic [IDX_W-1:0] fileIdx;
	logic [DATA_W-1:0] fileRdData, fileWrData, accOut;
	logic fileWrEn, carryFlag, halfByteOverflowFlag, zeroFlag, cycleDone, opAccepted;
	int failures = 0;
	int num_checks = 0;
	aac_core dut_u (.core_clk(core_clk), .resetn(resetn), .insnWord(insnWord),
		.insnValid(insnValid), .fileIdx(fileIdx), .fileRdData(fileRdData),
		.fileWrEn(fileWrEn), .fileWrData(fileWrData), .accOut(accOut),
		.carryFlag(carryFlag), .halfByteOverflowFlag(halfByteOverflowFlag),
		.zeroFlag(zeroFlag), .cycleDone(cycleDone), .opAccepted(opAccepted));
	aac_file_model fileModel_u (.core_clk(core_clk), .fileIdx(fileIdx), .fileWrEn(fileWrEn),
		.fileWrData(fileWrData), .fileRdData(fileRdData));
	initial forever #5 core_clk = ~core_clk;
	// ----------------------------------------
	// compare and report
	// ----------------------------------------
	task automatic chk(string what, logic [8:0] exp, logic [8:0] got);
		num_checks++;
		if (exp !== got) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic results();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// one op: offer word until taken, then wait for done; sampled at falling edges
	// flags are {carry, half, zero}; eWr set means the result goes to the file register
	task automatic run(logic [13:0] w, logic [7:0] eRes, logic [2:0] eFlag, logic eWr);
		logic [7:0] acc0;
		logic wr;
		int n;
		acc0 = accOut;
		wr = 0;
		n = 0;
		@(posedge core_clk);
		insnWord <= w;
		insnValid <= 1;
		do begin
			@(negedge core_clk);
			n++;
		end while (opAccepted !== 1'b1 && n < 8);
		if (n >= 8) begin
			chk("accept", 9'h001, 9'h000);
			results();
		end
		@(posedge core_clk);
		insnValid <= 0;
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
			wr |= fileWrEn;
		end while (cycleDone !== 1'b1 && n < 8);
		// done shows in the cycle after the fourth phase, one past the phase count
		chk("latency", 9'(OSC_PER_CYCLE + 1), 9'(n));
		if (cycleDone !== 1'b1) begin
			results();
		end
		chk("write", 9'(eWr), 9'(wr));
		chk("acc", eWr ? acc0 : eRes, 9'(accOut));
		chk("flags", 9'(eFlag), 9'({carryFlag, halfByteOverflowFlag, zeroFlag}));
		if (eWr) chk("wrdata", 9'(eRes), 9'(fileWrData));
		chk("idx", 9'(w[IDX_W-1:0]), 9'(fileIdx));
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	// immediates: plain add, add with both carries and masked low field bit, and to zero
	task automatic test_imm();
		run({2'h3, 4'he, 8'h17}, 8'h17, 3'b000, 0);
		run({2'h3, 4'hf, 8'hf9}, 8'h10, 3'b110, 0);
		run({2'h3, 4'h9, 8'h0f}, 8'h00, 3'b111, 0);
		$display("test imm done");
	endtask
	// register ops with both destinations, top and bottom index
	task automatic test_reg();
		run({2'h0, 4'h7, 1'b0, 7'h7f}, 8'hda, 3'b000, 0);
		run({2'h0, 4'h7, 1'b1, 7'h00}, 8'h7f, 3'b100, 1);
		run({2'h0, 4'h5, 1'b1, 7'h02}, 8'h82, 3'b100, 1);
		run({2'h0, 4'h5, 1'b0, 7'h05}, 8'h80, 3'b100, 0);
		$display("test reg done");
	endtask
	// other word changes nothing; then read back the cell written above
	task automatic test_other();
		run(14'h0000, 8'h80, 3'b100, 0);
		run({2'h0, 4'h7, 1'b0, 7'h00}, 8'hff, 3'b000, 0);
		$display("test other done");
	endtask
	// two words back to back: the second is taken in the last phase of the first
	task automatic test_b2b();
		int n;
		n = 0;
		@(posedge core_clk);
		insnWord <= {2'h3, 4'he, 8'h01}; // 0xff plus one wraps to zero
		insnValid <= 1;
		@(posedge core_clk);
		insnWord <= {2'h3, 4'hf, 8'h35}; // idle, so the first word was taken at this edge
		do begin
			@(negedge core_clk);
			n++;
		end while (opAccepted !== 1'b1 && n < 8);
		chk("spacing", 9'(OSC_PER_CYCLE), 9'(n));
		if (n >= 8) begin
			results();
		end
		@(posedge core_clk);
		insnValid <= 0;
		@(negedge core_clk);
		chk("done", 9'h001, 9'(cycleDone));
		chk("acc", 9'h000, 9'(accOut));
		chk("flags", 9'h007, 9'({carryFlag, halfByteOverflowFlag, zeroFlag}));
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (cycleDone !== 1'b1 && n < 8);
		chk("spacing", 9'(OSC_PER_CYCLE), 9'(n));
		if (n >= 8) begin
			results();
		end
		chk("acc", 9'h035, 9'(accOut));
		chk("flags", 9'h000, 9'({carryFlag, halfByteOverflowFlag, zeroFlag}));
		$display("test b2b done");
	endtask
	// reset while idle clears accumulator, flags and write port, then a word runs again
	task automatic test_reset();
		@(posedge core_clk);
		resetn <= 0;
		repeat (2) @(posedge core_clk);
		resetn <= 1;
		@(negedge core_clk);
		chk("acc", 9'(ACC_RESET), 9'(accOut));
		chk("flags", 9'h000, 9'({carryFlag, halfByteOverflowFlag, zeroFlag}));
		chk("wrport", 9'h000, 9'({fileWrEn, fileWrData}));
		run({2'h3, 4'he, 8'h80}, 8'h80, 3'b000, 0);
		$display("test reset done");
	endtask
	// reset for eight cycles, then run every scenario
	initial begin
		repeat (8) @(posedge core_clk);
		resetn <= 1;
		test_imm();
		test_reg();
		test_other();
		test_b2b();
		test_reset();
		results();
	end
endmodule
